/* rtl/host_port_pkg.sv */
package host_port_pkg;

  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 6;
  localparam int DIR_BIT = 15;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h0f;

  // Register offsets
  localparam logic [5:0] PROCESSING_DISABLE_CTRL_ADDR = 6'h00;
  localparam logic [5:0] DETECTED_ERROR_FLAGS_ADDR = 6'h01;
  localparam logic [5:0] RECEIVED_CHECK_FLAGS_ADDR = 6'h03;
  localparam logic [5:0] DETECTED_VIDEO_STD_ADDR = 6'h04;
  localparam logic [5:0] ANCILLARY_KIND_FIRST = 6'h05;
  localparam logic [5:0] ANCILLARY_KIND_LAST = 6'h09;
  localparam logic [5:0] PAYLOAD_ID_FIRST = 6'h0c;
  localparam logic [5:0] PAYLOAD_ID_LAST = 6'h0d;
  localparam logic [5:0] RASTER_FIRST = 6'h0e;
  localparam logic [5:0] RASTER_LAST = 6'h11;
  localparam logic [5:0] CHECK_RANGE_FIRST = 6'h12;
  localparam logic [5:0] CHECK_RANGE_LAST = 6'h19;
  localparam logic [5:0] ERROR_INDICATION_MASK_ADDR = 6'h1a;

  localparam int ANC_COUNT = 5;
  localparam int RANGE_COUNT = 8;

  // Writable bits of the processing disable register, reset values
  localparam logic [15:0] PROCESSING_DISABLE_WMASK = 16'h0139;
  localparam logic [15:0] PROCESSING_DISABLE_RESET = 16'h0000;
  localparam logic [15:0] RW_RESET = 16'h0000;
  localparam logic [15:0] CHECK_FLAGS_WMASK = 16'h7fff;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_COMMAND = 2'b01,
    PHASE_DATA = 2'b10,
    PHASE_DONE = 2'b11
  } phase_e;

  // Completed access handed from the serial engine to the register file
  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [15:0] data;
  } access_s;

  // Shared scan pins as seen by the test controller
  typedef struct packed {
    logic mode_select;
    logic data_in;
    logic test_clock;
    logic test_reset_n;
  } scan_pins_s;

endpackage : host_port_pkg

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
  import host_port_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  // First stage feeds only the second one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      first_stage <= '0;
      sync_out <= '0;
    end else begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule : pin_sync

/* rtl/host_reg_file.sv */
`timescale 1ns/1ps
module host_reg_file
  import host_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] read_addr,
  output logic [15:0] read_data,
  input wire logic commit,
  input wire access_s commit_access,
  input wire logic [15:0] error_flags_in,
  input wire logic check_flags_valid,
  input wire logic [15:0] check_flags_in,
  input wire logic [15:0] video_std_in,
  input wire logic [31:0] payload_id_in,
  input wire logic [63:0] raster_in,
  output logic [15:0] processing_disable_ctrl,
  output logic [79:0] ancillary_kind_select,
  output logic [127:0] check_range_config,
  output logic [15:0] error_indication_mask
);

  logic [15:0] anc_mem [ANC_COUNT];
  logic [15:0] range_mem [RANGE_COUNT];
  logic [15:0] received_check_flags;
  logic wr;

  function automatic logic in_span(input logic [5:0] a, input logic [5:0] lo,
                                   input logic [5:0] hi);
    in_span = (a >= lo) && (a <= hi);
  endfunction : in_span

  assign wr = commit && commit_access.write;

  // read-only or unused targets ignore writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      processing_disable_ctrl <= PROCESSING_DISABLE_RESET;
      error_indication_mask <= RW_RESET;
    end else if (wr) begin
      if (commit_access.addr == PROCESSING_DISABLE_CTRL_ADDR) begin
        processing_disable_ctrl <= commit_access.data & PROCESSING_DISABLE_WMASK;
      end else if (commit_access.addr == ERROR_INDICATION_MASK_ADDR) begin
        error_indication_mask <= commit_access.data;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < ANC_COUNT; g++) begin : g_anc
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          anc_mem[g] <= RW_RESET;
        end else if (wr && commit_access.addr == ANCILLARY_KIND_FIRST + 6'(g)) begin
          anc_mem[g] <= commit_access.data;
        end
      end
      assign ancillary_kind_select[g*16 +: 16] = anc_mem[g];
    end
    for (g = 0; g < RANGE_COUNT; g++) begin : g_range
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          range_mem[g] <= RW_RESET;
        end else if (wr && commit_access.addr == CHECK_RANGE_FIRST + 6'(g)) begin
          range_mem[g] <= commit_access.data;
        end
      end
      assign check_range_config[g*16 +: 16] = range_mem[g];
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      received_check_flags <= 16'h0000;
    end else if (check_flags_valid) begin
      received_check_flags <= received_check_flags | (check_flags_in & CHECK_FLAGS_WMASK);
    end
  end

  // each register on its own address
  always_comb begin
    read_data = 16'h0000;
    if (read_addr == PROCESSING_DISABLE_CTRL_ADDR) begin
      read_data = processing_disable_ctrl;
    end else if (read_addr == DETECTED_ERROR_FLAGS_ADDR) begin
      read_data = error_flags_in;
    end else if (read_addr == RECEIVED_CHECK_FLAGS_ADDR) begin
      read_data = received_check_flags;
    end else if (read_addr == DETECTED_VIDEO_STD_ADDR) begin
      read_data = video_std_in;
    end else if (in_span(read_addr, ANCILLARY_KIND_FIRST, ANCILLARY_KIND_LAST)) begin
      read_data = anc_mem[3'(read_addr - ANCILLARY_KIND_FIRST)];
    end else if (in_span(read_addr, PAYLOAD_ID_FIRST, PAYLOAD_ID_LAST)) begin
      read_data = payload_id_in[{read_addr[0], 4'h0} +: 16];
    end else if (in_span(read_addr, RASTER_FIRST, RASTER_LAST)) begin
      read_data = raster_in[6'(read_addr - RASTER_FIRST) * 16 +: 16];
    end else if (in_span(read_addr, CHECK_RANGE_FIRST, CHECK_RANGE_LAST)) begin
      read_data = range_mem[3'(read_addr - CHECK_RANGE_FIRST)];
    end else if (read_addr == ERROR_INDICATION_MASK_ADDR) begin
      read_data = error_indication_mask;
    end
  end

endmodule : host_reg_file

/* rtl/serial_host_register_port.sv */
`timescale 1ns/1ps
// How it works
// - Each access: 16-bit command word, then 16-bit data word in or out.
// - Command MSB first: direction bit, nine reserved bits, 6-bit address.
// - Direction bit 1 reads, 0 writes.
// - Command bits captured on burst clock rising edges.
// - Write data may follow last command bit; sampled on rising edges.
// - Read MSB driven after last command falling edge; later bits on falling edges.
// - Serial output undriven whenever not selected, except that strap high passes scan out and its enable.
// - Strap low: shared pins form the serial register port.
// - Strap high: pins become scan select, out, in, clock; reset is test reset.
// - Boundary scan enabled only while strap selects test.
// - Every register individually addressable; narrow status may share addresses.
// - Check flags sticky, not cleared by reads or source loss.
module serial_host_register_port
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic port_role_strap,
  input wire logic select_n,
  input wire logic burst_clk,
  input wire logic host_serial_in,
  output logic host_serial_out,
  output logic host_serial_out_oe,
  input wire logic scan_data_out,
  input wire logic scan_data_out_oe,
  output scan_pins_s scan_pins,
  output logic scan_enable,
  input wire logic [15:0] error_flags_in,
  input wire logic check_flags_valid,
  input wire logic [15:0] check_flags_in,
  input wire logic [15:0] video_std_in,
  input wire logic [31:0] payload_id_in,
  input wire logic [63:0] raster_in,
  output logic [15:0] processing_disable_ctrl,
  output logic [79:0] ancillary_kind_select,
  output logic [127:0] check_range_config,
  output logic [15:0] error_indication_mask
);

  logic rst_meta;
  logic rst_n;
  logic [3:0] pins_sync;
  logic strap_q;
  logic sel_q;
  logic sclk_q;
  logic host_serial_in_q;
  logic sclk_prev;
  logic sclk_rise;
  logic sclk_fall;
  logic host_mode;
  logic selected;
  phase_e phase;
  logic [4:0] bit_count;
  logic [15:0] shift_in;
  logic is_read;
  logic [5:0] reg_addr;
  logic [15:0] shift_out;
  logic [15:0] read_data;
  logic commit;
  access_s commit_access;
  logic out_bit;
  logic sclk_prev_loaded;
  logic in_command;
  logic in_data;
  logic cmd_last;
  logic data_last;
  logic first_fall;
  logic host_drive;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // One synchroniser for all four pins keeps their relative timing
  pin_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .async_in({port_role_strap,
               ~select_n,
               burst_clk,
               host_serial_in}),
    .sync_out(pins_sync)
  );

  assign strap_q = pins_sync[3];
  assign sel_q = pins_sync[2];
  assign sclk_q = pins_sync[1];
  assign host_serial_in_q = pins_sync[0];

  // Half periods under one ref_clk cycle could be missed; 6.6 MHz leaves room
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_q;
    end
  end

  // host port active only with strap low
  assign host_mode = !strap_q;
  assign selected = host_mode && sel_q;
  assign sclk_rise = selected && sclk_q && !sclk_prev;
  assign sclk_fall = selected && !sclk_q && sclk_prev;

  // Last bit of a 16-bit word
  function automatic logic word_end(input logic [4:0] count);
    word_end = (count == LAST_BIT_INDEX);
  endfunction : word_end

  // Frame position, shared by the processes below
  assign in_command = selected && (phase == PHASE_COMMAND);
  assign in_data = selected && (phase == PHASE_DATA);
  assign cmd_last = sclk_rise && in_command && word_end(bit_count);
  // last data bit lands on this rise
  assign data_last = sclk_rise && in_data && word_end(bit_count);

  // passive: only host select and clock move the engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PHASE_IDLE;
    end else if (!selected) begin
      phase <= PHASE_IDLE;
    end else begin
      case (phase)
        PHASE_IDLE: begin
          // One settling cycle; the host leaves far more before its first edge
          phase <= PHASE_COMMAND;
        end
        PHASE_COMMAND: begin
          if (cmd_last) begin
            phase <= PHASE_DATA;
          end
        end
        PHASE_DATA: begin
          if (data_last) begin
            phase <= PHASE_DONE;
          end
        end
        PHASE_DONE: begin
          phase <= PHASE_DONE;
        end
        default: begin
          phase <= PHASE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_count <= 5'h00;
    end else if (!in_command && !in_data) begin
      bit_count <= 5'h00;
    end else if (cmd_last || data_last) begin
      bit_count <= 5'h00;
    end else if (sclk_rise) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_in <= 16'h0000;
    end else if (sclk_rise && (in_command || in_data)) begin
      shift_in <= {shift_in[14:0], host_serial_in_q};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      is_read <= 1'b0;
      reg_addr <= 6'h00;
    end else if (cmd_last) begin
      // one means read; reserved bits are ignored
      is_read <= shift_in[14];
      reg_addr <= {shift_in[4:0], host_serial_in_q};
    end
  end

  // commit only once the full data word has arrived
  always_comb begin
    commit = data_last;
    // Reads end here too, but with write low nothing changes
    commit_access.write = !is_read;
    commit_access.addr = reg_addr;
    commit_access.data = {shift_in[14:0], host_serial_in_q};
  end

  // first data-phase fall loads the MSB
  assign first_fall = sclk_fall && in_data && !sclk_prev_loaded;

  // Status is read live; a change after the load shows only in the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_out <= 16'h0000;
    end else if (first_fall) begin
      shift_out <= {read_data[14:0], 1'b0};
    end else if (sclk_fall && in_data) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  // later bits move on falling edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_bit <= 1'b0;
    end else if (!selected) begin
      out_bit <= 1'b0;
    end else if (first_fall) begin
      out_bit <= read_data[15];
    end else if (sclk_fall && in_data) begin
      out_bit <= shift_out[15];
    end
  end

  // Marks that the MSB has been loaded in this data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_loaded <= 1'b0;
    end else if (!in_data) begin
      sclk_prev_loaded <= 1'b0;
    end else if (sclk_fall) begin
      sclk_prev_loaded <= 1'b1;
    end
  end

  // Registers live in their own module; this one only moves bits
  host_reg_file u_reg_file (
    .clk(ref_clk),
    .rst_n(rst_n),
    .read_addr(reg_addr),
    .read_data(read_data),
    .commit(commit),
    .commit_access(commit_access),
    .error_flags_in(error_flags_in),
    .check_flags_valid(check_flags_valid),
    .check_flags_in(check_flags_in),
    .video_std_in(video_std_in),
    .payload_id_in(payload_id_in),
    .raster_in(raster_in),
    .processing_disable_ctrl(processing_disable_ctrl),
    .ancillary_kind_select(ancillary_kind_select),
    .check_range_config(check_range_config),
    .error_indication_mask(error_indication_mask)
  );

  // drive only in the read data phase, once the MSB is loaded
  assign host_drive = in_data && is_read && sclk_prev_loaded;

  // output driven during a selected read, or by scan out and its enable with strap high
  always_comb begin
    host_serial_out = 1'b0;
    host_serial_out_oe = 1'b0;
    if (host_drive) begin
      host_serial_out = out_bit;
      host_serial_out_oe = 1'b1;
    end else if (strap_q) begin
      host_serial_out = scan_data_out;
      host_serial_out_oe = scan_data_out_oe;
    end
  end

  // pins reused by the scan controller, reset as test reset
  // scan enabled only with strap high
  always_comb begin
    scan_enable = strap_q;
    scan_pins.mode_select = 1'b1;
    scan_pins.data_in = 1'b1;
    scan_pins.test_clock = 1'b0;
    scan_pins.test_reset_n = 1'b0;
    if (strap_q) begin
      // Pins pass at their own level; the scan controller times them
      scan_pins.mode_select = select_n;
      scan_pins.data_in = host_serial_in;
      scan_pins.test_clock = burst_clk;
      scan_pins.test_reset_n = reset_n;
    end
  end

endmodule : serial_host_register_port

/* test/serial_host_register_port_chk.sv */
`timescale 1ns/1ps
module serial_host_register_port_chk
  import host_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic port_role_strap,
  input wire logic select_n,
  input wire logic burst_clk,
  input wire logic host_serial_out,
  input wire logic host_serial_out_oe,
  input wire logic scan_data_out_oe,
  input wire logic scan_enable,
  input wire logic [15:0] processing_disable_ctrl,
  input wire logic [15:0] error_indication_mask
);
  logic clk_d;
  logic [3:0] hi_cnt;
  logic [3:0] rise_cnt;
  logic [3:0] fall_cnt;
  function automatic logic [3:0] sat(input logic [3:0] v);
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction : sat
  // Saturating ages of host events, so lag bounds stay exact
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_d <= 1'b0;
      hi_cnt <= 4'h0;
      rise_cnt <= 4'hf;
      fall_cnt <= 4'hf;
    end else begin
      clk_d <= burst_clk;
      hi_cnt <= (select_n && !port_role_strap) ? sat(hi_cnt) : 4'h0;
      rise_cnt <= (burst_clk && !clk_d) ? 4'h0 : sat(rise_cnt);
      fall_cnt <= (!burst_clk && clk_d) ? 4'h0 : sat(fall_cnt);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_idle_long;
    hi_cnt > 4'h7;
  endsequence
  sequence s_scan_steady;
    (port_role_strap && scan_enable && $stable(scan_data_out_oe)) [*3];
  endsequence
  property p_oe_idle;
    s_idle_long |-> !host_serial_out_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("driven unselected");
  property p_scan_on;
    $rose(port_role_strap) |-> ##[1:4] scan_enable;
  endproperty
  a_scan_on: assert property (p_scan_on) else $error("scan not enabled");
  property p_scan_off;
    $fell(port_role_strap) |-> ##[1:4] !scan_enable;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("scan not left");
  property p_scan_oe;
    s_scan_steady |-> host_serial_out_oe == scan_data_out_oe;
  endproperty
  a_scan_oe: assert property (p_scan_oe) else $error("scan enable not passed");
  property p_oe_start;
    $rose(host_serial_out_oe) && !port_role_strap && !scan_enable
      |-> !select_n && fall_cnt < 4'h7;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("read start late");
  property p_out_on_fall;
    host_serial_out_oe && $past(host_serial_out_oe) && $changed(host_serial_out)
      && !scan_enable |-> fall_cnt < 4'h7;
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("bit off fall");
  property p_pdc_mask;
    (processing_disable_ctrl & ~PROCESSING_DISABLE_WMASK) == 16'h0000;
  endproperty
  a_pdc_mask: assert property (p_pdc_mask) else $error("unused bit set");
  property p_write_window;
    !$stable({processing_disable_ctrl, error_indication_mask})
      |-> hi_cnt < 4'h6 && rise_cnt < 4'h7;
  endproperty
  a_write_window: assert property (p_write_window) else $error("stray write");
endmodule : serial_host_register_port_chk

bind serial_host_register_port serial_host_register_port_chk i_serial_host_register_port_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .port_role_strap(port_role_strap),
  .select_n(select_n), .burst_clk(burst_clk), .host_serial_out(host_serial_out),
  .host_serial_out_oe(host_serial_out_oe), .scan_data_out_oe(scan_data_out_oe),
  .scan_enable(scan_enable), .processing_disable_ctrl(processing_disable_ctrl),
  .error_indication_mask(error_indication_mask));

/* test/host_model.sv */
`timescale 1ns/1ps
module host_model (
  output logic select_n,
  output logic burst_clk,
  output logic host_serial_in,
  input wire logic line_in,
  input wire logic line_oe
);
  localparam int HALF = 24;
  initial begin
    select_n = 1'b1;
    burst_clk = 1'b0;
    host_serial_in = 1'b0;
  end
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, input int bits,
                      output logic [15:0] rd, output logic oe_any);
    logic [31:0] word;
    word = {cmd, wd};
    rd = 16'h0000;
    oe_any = 1'b0;
    select_n = 1'b0;
    #HALF;
    for (int i = 0; i < bits; i++) begin
      host_serial_in = (i < 32) ? word[31-i] : 1'b1;
      #HALF;
      burst_clk = 1'b1;
      if (i >= 16 && i < 32) begin
        rd[31-i] = line_oe ? line_in : ~line_in;
        oe_any = oe_any | line_oe;
      end
      #HALF;
      burst_clk = 1'b0;
    end
    #HALF;
    select_n = 1'b1;
    // Released line flips so a stale level cannot pass
    host_serial_in = ~host_serial_in;
    #100;
  endtask : xfer
endmodule : host_model

/* test/serial_host_register_port_test.sv */
`timescale 1ns/1ps
module serial_host_register_port_test;
  import host_port_pkg::*;
  localparam logic [15:0] ERR_IN = 16'h1234;
  localparam logic [15:0] STD_IN = 16'h0a5e;
  localparam logic [31:0] PAY_IN = 32'h89ab4567;
  localparam logic [63:0] RAS_IN = 64'h0fed1357cba92468;
  logic ref_clk, reset_n, port_role_strap, select_n, burst_clk, host_serial_in;
  logic host_serial_out, host_serial_out_oe, scan_data_out, scan_data_out_oe;
  logic scan_enable, check_flags_valid, oe_seen;
  logic [15:0] check_flags_in, processing_disable_ctrl, error_indication_mask, rd_data;
  logic [79:0] ancillary_kind_select;
  logic [127:0] check_range_config;
  logic [15:0] mirror [64];
  scan_pins_s scan_pins;
  int mismatches = 0;
  int compares = 0;
  serial_host_register_port i_serial_host_register_port (.ref_clk(ref_clk),
    .reset_n(reset_n), .port_role_strap(port_role_strap), .select_n(select_n),
    .burst_clk(burst_clk), .host_serial_in(host_serial_in),
    .host_serial_out(host_serial_out), .host_serial_out_oe(host_serial_out_oe),
    .scan_data_out(scan_data_out), .scan_data_out_oe(scan_data_out_oe),
    .scan_pins(scan_pins), .scan_enable(scan_enable), .error_flags_in(ERR_IN),
    .check_flags_valid(check_flags_valid), .check_flags_in(check_flags_in),
    .video_std_in(STD_IN), .payload_id_in(PAY_IN), .raster_in(RAS_IN),
    .processing_disable_ctrl(processing_disable_ctrl),
    .ancillary_kind_select(ancillary_kind_select),
    .check_range_config(check_range_config),
    .error_indication_mask(error_indication_mask));
  host_model i_host_model (.select_n(select_n), .burst_clk(burst_clk),
    .host_serial_in(host_serial_in), .line_in(host_serial_out),
    .line_oe(host_serial_out_oe));
  function automatic logic [15:0] wmask(input int a);
    if (a == 0) return PROCESSING_DISABLE_WMASK;
    if (a inside {[5:9], [18:26]}) return 16'hffff;
    return 16'h0000;
  endfunction : wmask
  function automatic logic [15:0] port_val(input int a);
    if (a == 0) return processing_disable_ctrl;
    if (a == 26) return error_indication_mask;
    if (a <= 9) return ancillary_kind_select[16*(a-5) +: 16];
    return check_range_config[16*(a-18) +: 16];
  endfunction : port_val
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic acc(input logic [15:0] cmd, input logic [15:0] wd, input int bits);
    i_host_model.xfer(cmd, wd, bits, rd_data, oe_seen);
    check({15'h0, host_serial_out_oe}, 16'h0000);
  endtask : acc
  task automatic wr(input int a, input logic [15:0] d);
    acc({10'h000, 6'(a)}, d, 32);
    check({15'h0, oe_seen}, 16'h0000);
  endtask : wr
  task automatic rd(input int a);
    acc({10'h200, 6'(a)}, 16'h0000, 32);
    check({15'h0, oe_seen}, 16'h0001);
  endtask : rd
  task automatic t_map();
    logic [15:0] d;
    for (int a = 0; a < 32; a++) begin
      d = 16'ha5c3 ^ 16'(a);
      rd(a);
      check(rd_data, mirror[a]);
      wr(a, d);
      mirror[a] = (mirror[a] & ~wmask(a)) | (d & wmask(a));
      rd(a);
      check(rd_data, mirror[a]);
      if (wmask(a) != 16'h0000) check(port_val(a), mirror[a]);
    end
  endtask : t_map
  task automatic pulse(input logic [15:0] f);
    @(posedge ref_clk);
    check_flags_in <= f;
    check_flags_valid <= 1'b1;
    @(posedge ref_clk);
    check_flags_valid <= 1'b0;
    check_flags_in <= 16'h0000;
  endtask : pulse
  task automatic t_sticky();
    pulse(16'h8005);
    rd(3);
    check(rd_data, 16'h0005);
    pulse(16'h0300);
    rd(3);
    rd(3);
    check(rd_data, 16'h0305);
  endtask : t_sticky
  task automatic t_abort();
    wr(26, 16'h0f0f);
    acc(16'h001a, 16'hf0f0, 31);
    rd(26);
    check(rd_data, 16'h0f0f);
    acc(16'h001a, 16'hf0f0, 9);
    acc(16'h001a, 16'h5a5a, 48);
    check(error_indication_mask, 16'h5a5a);
    wr(26, 16'h3c3c);
    check(error_indication_mask, 16'h3c3c);
  endtask : t_abort
  task automatic t_scan();
    @(posedge ref_clk);
    port_role_strap <= 1'b1;
    scan_data_out_oe <= 1'b1;
    scan_data_out <= 1'b1;
    repeat (8) @(posedge ref_clk);
    check({15'h0, scan_enable}, 16'h0001);
    check({14'h0, host_serial_out_oe, host_serial_out}, 16'h0003);
    i_host_model.xfer(16'h001a, 16'h1111, 32, rd_data, oe_seen);
    check(error_indication_mask, 16'h3c3c);
    check({15'h0, scan_pins.data_in}, {15'h0, host_serial_in});
    check({15'h0, scan_pins.test_reset_n}, 16'h0001);
    check({14'h0, scan_pins.mode_select, scan_pins.test_clock}, 16'h0002);
    @(posedge ref_clk);
    port_role_strap <= 1'b0;
    scan_data_out_oe <= 1'b0;
    repeat (8) @(posedge ref_clk);
    check({15'h0, scan_enable}, 16'h0000);
  endtask : t_scan
  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Whole run needs about 180 us
  initial begin
    #400000;
    mismatches++;
    stop_test();
  end
  initial begin
    reset_n = 1'b0;
    port_role_strap = 1'b0;
    scan_data_out = 1'b0;
    scan_data_out_oe = 1'b0;
    check_flags_valid = 1'b0;
    check_flags_in = 16'h0000;
    foreach (mirror[i]) mirror[i] = 16'h0000;
    mirror[1] = ERR_IN;
    mirror[4] = STD_IN;
    mirror[12] = PAY_IN[15:0];
    mirror[13] = PAY_IN[31:16];
    for (int k = 0; k < 4; k++) mirror[14+k] = RAS_IN[16*k +: 16];
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_map();
    t_sticky();
    t_abort();
    t_scan();
    stop_test();
  end
endmodule : serial_host_register_port_test
